//--- hdl/nvmp_consts.svh
// offsets, field positions and reset values of the nvm protection block
`ifndef NVMP_CONSTS_SVH
`define NVMP_CONSTS_SVH
`define NVMP_OFS_WP     22'h300006
`define NVMP_OFS_RO     22'h300008
`define NVMP_OFS_TR     22'h30000a
`define NVMP_OFS_REV    22'h3ffffc
`define NVMP_OFS_PART   22'h3ffffe
`define NVMP_BIT_LVP    13
`define NVMP_BIT_SCAN   12
`define NVMP_BIT_EEPROM_WRITE_GUARD_N   10
`define NVMP_BIT_BOOT_WRITE_GUARD_N   9
`define NVMP_BIT_CFG_WRITE_GUARD_N   8
`define NVMP_USER_HI    7
`define NVMP_USER_LO    0
`define NVMP_BIT_CPD    1
`define NVMP_BIT_CP     0
`define NVMP_BIT_BOOT_TABLE_READ_GUARD_N  9
`define NVMP_FAM_HI     15
`define NVMP_FAM_LO     12
`define NVMP_MAJ_HI     11
`define NVMP_MAJ_LO     6
`define NVMP_MIN_HI     5
`define NVMP_MIN_LO     0
`define NVMP_WP_ERASED  16'h37ff
`define NVMP_RO_ERASED  16'h0003
`define NVMP_TR_ERASED  16'h02ff
`define NVMP_BOOT_REGION 4'h8
`define NVMP_ZERO16     16'h0000
`define NVMP_ZERO8      8'h00
`endif

//--- hdl/nvmp_pkg.sv
// types shared by the nvm protection block
package nvmp_pkg;
    typedef enum logic [1:0] {
        SP_PROG   = 2'b00,
        SP_EEPROM = 2'b01,
        SP_CFG    = 2'b10
    } nvmp_space_t;

    typedef enum logic {
        PH_LOAD = 1'b0,
        PH_RUN  = 1'b1
    } nvmp_phase_t;
endpackage

//--- hdl/nvmp_sync.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module nvmp_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (!rstn) begin
                meta_reg[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_reg[i] <= async_in[i];
                sync_out[i] <= meta_reg[i];
            end
        end
    end
endmodule

//--- hdl/nvmp_region.sv
// maps a program memory byte address to its protection region
`timescale 1ns/1ps
`include "nvmp_consts.svh"
module nvmp_region #(
    parameter int              ADDR_W     = 17,
    parameter int              BLK_SHIFT  = 14,
    parameter logic [ADDR_W-1:0] BOOT_BYTES = 17'h00800
) (
    input  wire logic [ADDR_W-1:0] addr,
    output logic      [3:0]        region
);
    // boot block is carved from the bottom of user block 0
    always_comb begin
        if (addr < BOOT_BYTES) begin
            region = `NVMP_BOOT_REGION;
        end else begin
            region = {1'b0, addr[BLK_SHIFT+2:BLK_SHIFT]};
        end
    end
endmodule

//--- hdl/nvmp_top.sv
// nvm write, readout and table read protection with its configuration words
`timescale 1ns/1ps
`include "nvmp_consts.svh"
module nvmp_top import nvmp_pkg::*; #(
    parameter int          ADDR_W     = 17,
    parameter int          BLK_SHIFT  = 14,
    parameter logic [16:0] BOOT_BYTES = 17'h00800,
    parameter logic [3:0]  FAMILY_ID  = 4'h5,    // arbitrary value
    parameter logic [5:0]  MAJOR_REV  = 6'h00,
    parameter logic [5:0]  MINOR_REV  = 6'h01,
    parameter logic [15:0] PART_CODE  = 16'h1234 // arbitrary value
) (
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic [21:0]       reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic [15:0]       cfg_wp_init,
    input  wire logic [15:0]       cfg_ro_init,
    input  wire logic [15:0]       cfg_tr_init,
    input  wire logic              lvp_session,
    input  wire logic              ext_reset_pin_enable,
    input  wire logic              scanner_module_off,
    input  wire logic              wr_req,
    input  wire nvmp_space_t       wr_space,
    input  wire logic [ADDR_W-1:0] wr_addr,
    output logic                   wr_commit,
    output logic                   wr_refused,
    input  wire logic              tr_req,
    input  wire logic [ADDR_W-1:0] tr_addr,
    input  wire logic [ADDR_W-1:0] tr_src_addr,
    input  wire logic [7:0]        tr_data_in,
    output logic                   tr_grant,
    output logic                   tr_refused,
    output logic      [7:0]        tr_data_out,
    output logic                   reset_pin_is_reset,
    output logic                   scanner_enable,
    output logic                   prog_readout_protected,
    output logic                   data_readout_protected
);
    nvmp_phase_t phase_reg;
    logic [15:0] wp_reg;
    logic [15:0] ro_reg;
    logic [15:0] tr_reg;
    logic [15:0] wp_act_reg;
    logic [15:0] ro_act_reg;
    logic [15:0] tr_act_reg;
    logic        session_s;
    logic [3:0]  wr_region;
    logic [3:0]  tr_region;
    logic [3:0]  src_region;
    logic        wr_ok;
    logic        tr_ok;
    logic [15:0] wp_next;
    logic [15:0] rdata_next;
    logic        cfg_open;
    logic [7:0]  user_wg;
    logic [7:0]  user_tg;

    nvmp_sync #(.W(1)) u_sync (
        .clock    (clock),
        .rstn     (rstn),
        .async_in (lvp_session),
        .sync_out (session_s)
    );

    nvmp_region #(.ADDR_W(ADDR_W), .BLK_SHIFT(BLK_SHIFT), .BOOT_BYTES(BOOT_BYTES)) u_wr_rgn (
        .addr   (wr_addr),
        .region (wr_region)
    );

    nvmp_region #(.ADDR_W(ADDR_W), .BLK_SHIFT(BLK_SHIFT), .BOOT_BYTES(BOOT_BYTES)) u_tr_rgn (
        .addr   (tr_addr),
        .region (tr_region)
    );

    nvmp_region #(.ADDR_W(ADDR_W), .BLK_SHIFT(BLK_SHIFT), .BOOT_BYTES(BOOT_BYTES)) u_src_rgn (
        .addr   (tr_src_addr),
        .region (src_region)
    );

    assign cfg_open = wp_act_reg[`NVMP_BIT_CFG_WRITE_GUARD_N];
    assign user_wg  = wp_act_reg[`NVMP_USER_HI:`NVMP_USER_LO];
    assign user_tg  = tr_act_reg[`NVMP_USER_HI:`NVMP_USER_LO];

    // first cycle after reset release picks up the programmed words
    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase_reg <= PH_LOAD;
        end else begin
            phase_reg <= PH_RUN;
        end
    end

    // active copies change only at load, from cfg_wp_init, cfg_ro_init and cfg_tr_init, so a register write never reaches them
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wp_act_reg <= `NVMP_WP_ERASED;
            ro_act_reg <= `NVMP_RO_ERASED;
            tr_act_reg <= `NVMP_TR_ERASED;
        end else if (phase_reg == PH_LOAD) begin
            // taken from the programmed image itself: the stored copy is still erased here
            wp_act_reg <= cfg_wp_init & `NVMP_WP_ERASED;
            ro_act_reg <= cfg_ro_init & `NVMP_RO_ERASED;
            tr_act_reg <= cfg_tr_init & `NVMP_TR_ERASED;
        end
    end

    always_comb begin
        wp_next = reg_wdata & `NVMP_WP_ERASED;
        if (session_s) begin
            wp_next[`NVMP_BIT_LVP] = wp_reg[`NVMP_BIT_LVP] | reg_wdata[`NVMP_BIT_LVP];
        end
    end

    // stored words: a copy loaded from the programmed image at each reset, readable by software
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wp_reg <= `NVMP_WP_ERASED;
            ro_reg <= `NVMP_RO_ERASED;
            tr_reg <= `NVMP_TR_ERASED;
        end else if (phase_reg == PH_LOAD) begin
            wp_reg <= cfg_wp_init & `NVMP_WP_ERASED;
            ro_reg <= cfg_ro_init & `NVMP_RO_ERASED;
            tr_reg <= cfg_tr_init & `NVMP_TR_ERASED;
        end else if (reg_wr && cfg_open) begin
            if (reg_addr == `NVMP_OFS_WP) begin
                wp_reg <= wp_next;
            end
            if (reg_addr == `NVMP_OFS_TR) begin
                tr_reg <= reg_wdata & `NVMP_TR_ERASED;
            end
            // readout word has no write path at all
        end
    end

    always_comb begin
        unique case (reg_addr)
            `NVMP_OFS_WP:   rdata_next = wp_reg;
            `NVMP_OFS_RO:   rdata_next = ro_reg;
            `NVMP_OFS_TR:   rdata_next = tr_reg;
            `NVMP_OFS_REV:  rdata_next = {FAMILY_ID, MAJOR_REV, MINOR_REV};
            `NVMP_OFS_PART: rdata_next = PART_CODE;
            default:        rdata_next = `NVMP_ZERO16;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            reg_rdata <= `NVMP_ZERO16;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= `NVMP_ZERO16;
        end
    end

    // write permission per target space and region
    always_comb begin
        unique case (wr_space)
            SP_EEPROM: wr_ok = wp_act_reg[`NVMP_BIT_EEPROM_WRITE_GUARD_N];
            SP_CFG:    wr_ok = cfg_open;
            SP_PROG: begin
                if (wr_region == `NVMP_BOOT_REGION) begin
                    wr_ok = wp_act_reg[`NVMP_BIT_BOOT_WRITE_GUARD_N];
                end else begin
                    wr_ok = user_wg[wr_region[2:0]];
                end
            end
            default:   wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_commit  <= 1'b0;
            wr_refused <= 1'b0;
        end else begin
            wr_commit  <= wr_req && wr_ok && (phase_reg == PH_RUN);
            wr_refused <= wr_req && !(wr_ok && (phase_reg == PH_RUN));
        end
    end

    // reads from inside the same region are always allowed
    always_comb begin
        if (tr_region == src_region) begin
            tr_ok = 1'b1;
        end else if (tr_region == `NVMP_BOOT_REGION) begin
            tr_ok = tr_act_reg[`NVMP_BIT_BOOT_TABLE_READ_GUARD_N];
        end else begin
            tr_ok = user_tg[tr_region[2:0]];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tr_grant    <= 1'b0;
            tr_refused  <= 1'b0;
            tr_data_out <= `NVMP_ZERO8;
        end else begin
            tr_grant    <= tr_req && tr_ok;
            tr_refused  <= tr_req && !tr_ok;
            tr_data_out <= (tr_req && tr_ok) ? tr_data_in : `NVMP_ZERO8;
        end
    end

    // pin and module controls follow the active words
    always_ff @(posedge clock) begin
        if (!rstn) begin
            reset_pin_is_reset     <= 1'b1;
            scanner_enable         <= 1'b0;
            prog_readout_protected <= 1'b0;
            data_readout_protected <= 1'b0;
        end else begin
            reset_pin_is_reset     <= wp_act_reg[`NVMP_BIT_LVP] | ext_reset_pin_enable;
            scanner_enable         <= wp_act_reg[`NVMP_BIT_SCAN] & ~scanner_module_off;
            prog_readout_protected <= ~ro_act_reg[`NVMP_BIT_CP];
            data_readout_protected <= ~ro_act_reg[`NVMP_BIT_CPD];
        end
    end

    chk_lvp_hold: assert property (@(posedge clock) disable iff (!rstn)
        (reg_wr && reg_addr == `NVMP_OFS_WP && session_s && phase_reg == PH_RUN
         && wp_reg[`NVMP_BIT_LVP]) |=> wp_reg[`NVMP_BIT_LVP])
        else $error("low-voltage enable cleared during session");

    chk_reset_pin: assert property (@(posedge clock) disable iff (!rstn)
        wp_act_reg[`NVMP_BIT_LVP] |=> reset_pin_is_reset)
        else $error("reset pin released while low-voltage enable set");

    chk_scan_on: assert property (@(posedge clock) disable iff (!rstn)
        (wp_act_reg[`NVMP_BIT_SCAN] && $changed(scanner_module_off))
        |=> scanner_enable != $past(scanner_enable))
        else $error("scanner not following module-off bit");

    chk_scan_off: assert property (@(posedge clock) disable iff (!rstn)
        !wp_act_reg[`NVMP_BIT_SCAN] |=> !scanner_enable)
        else $error("scanner on while unavailable");

    chk_eeprom_guard: assert property (@(posedge clock) disable iff (!rstn)
        (wr_req && wr_space == SP_EEPROM && phase_reg == PH_RUN)
        |=> wr_commit == $past(wp_act_reg[`NVMP_BIT_EEPROM_WRITE_GUARD_N]))
        else $error("eeprom write guard wrong");

    chk_boot_guard: assert property (@(posedge clock) disable iff (!rstn)
        (wr_req && wr_space == SP_PROG && wr_addr < BOOT_BYTES && !wp_act_reg[`NVMP_BIT_BOOT_WRITE_GUARD_N])
        |=> wr_refused && !wr_commit)
        else $error("boot block write let through");

    chk_cfg_guard: assert property (@(posedge clock) disable iff (!rstn)
        (reg_wr && !cfg_open && phase_reg == PH_RUN) |=> $stable(wp_reg) && $stable(tr_reg))
        else $error("configuration changed while guarded");

    chk_user_guard: assert property (@(posedge clock) disable iff (!rstn)
        (wr_req && wr_space == SP_PROG && wr_region != `NVMP_BOOT_REGION
         && phase_reg == PH_RUN) |=> wr_commit == $past(user_wg[wr_region[2:0]]))
        else $error("user block write guard wrong");

    chk_readout_ro: assert property (@(posedge clock) disable iff (!rstn)
        (phase_reg == PH_RUN) |=> $stable(ro_reg))
        else $error("readout word changed by software");

    chk_prog_readout: assert property (@(posedge clock) disable iff (!rstn)
        (phase_reg == PH_RUN) ##1 1'b1 |-> prog_readout_protected == !ro_act_reg[`NVMP_BIT_CP])
        else $error("program readout flag wrong");

    chk_data_readout: assert property (@(posedge clock) disable iff (!rstn)
        (phase_reg == PH_RUN) ##1 1'b1 |-> data_readout_protected == !ro_act_reg[`NVMP_BIT_CPD])
        else $error("data readout flag wrong");

    chk_boot_tblrd: assert property (@(posedge clock) disable iff (!rstn)
        (tr_req && tr_region == `NVMP_BOOT_REGION && src_region != `NVMP_BOOT_REGION
         && !tr_act_reg[`NVMP_BIT_BOOT_TABLE_READ_GUARD_N]) |=> tr_refused && tr_data_out == `NVMP_ZERO8)
        else $error("boot table read let through");

    chk_blk_tblrd: assert property (@(posedge clock) disable iff (!rstn)
        (tr_req && tr_region != `NVMP_BOOT_REGION && tr_region != src_region)
        |=> tr_grant == $past(user_tg[tr_region[2:0]]))
        else $error("block table read guard wrong");

    chk_rev_fields: assert property (@(posedge clock) disable iff (!rstn)
        (reg_rd && reg_addr == `NVMP_OFS_REV)
        |=> reg_rdata[`NVMP_MAJ_HI:`NVMP_MAJ_LO] == MAJOR_REV
         && reg_rdata[`NVMP_MIN_HI:`NVMP_MIN_LO] == MINOR_REV)
        else $error("revision fields wrong");

    chk_refuse_quiet: assert property (@(posedge clock) disable iff (!rstn)
        (tr_refused |-> tr_data_out == `NVMP_ZERO8) and (wr_refused |-> !wr_commit))
        else $error("refused access leaked");

    chk_wr_answer: assert property (@(posedge clock) disable iff (!rstn)
        wr_req |=> (wr_commit ^ wr_refused))
        else $error("write request not answered exactly once");

    chk_load_copy: assert property (@(posedge clock) disable iff (!rstn)
        (phase_reg == PH_LOAD) ##1 (phase_reg == PH_RUN) |=> wp_act_reg == $past(wp_reg))
        else $error("active word not latched");

    cov_wr_refused: cover property (@(posedge clock) disable iff (!rstn) wr_refused);
    cov_wr_commit:  cover property (@(posedge clock) disable iff (!rstn) wr_commit);
    cov_tr_refused: cover property (@(posedge clock) disable iff (!rstn) tr_refused);
    cov_tr_grant:   cover property (@(posedge clock) disable iff (!rstn) tr_grant);
    cov_lvp_keep:   cover property (@(posedge clock) disable iff (!rstn)
        reg_wr && session_s && reg_addr == `NVMP_OFS_WP && !reg_wdata[`NVMP_BIT_LVP]);
endmodule

//--- sim/nvmp_top_tb_top.sv
// self-checking bench for the nvm protection block
`timescale 1ns/1ps
`include "nvmp_consts.svh"
module nvmp_top_tb_top import nvmp_pkg::*;;
    localparam logic [3:0]  TB_FAMILY = 4'h3;    // arbitrary value
    localparam logic [5:0]  TB_MAJOR  = 6'h2a;
    localparam logic [5:0]  TB_MINOR  = 6'h15;
    localparam logic [15:0] TB_PART   = 16'hc0de; // arbitrary value

    logic        clock;
    logic        rstn;
    logic [21:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [15:0] cfg_wp_init;
    logic [15:0] cfg_ro_init;
    logic [15:0] cfg_tr_init;
    logic        lvp_session;
    logic        ext_reset_pin_enable;
    logic        scanner_module_off;
    logic        wr_req;
    nvmp_space_t wr_space;
    logic [16:0] wr_addr;
    logic        wr_commit;
    logic        wr_refused;
    logic        tr_req;
    logic [16:0] tr_addr;
    logic [16:0] tr_src_addr;
    logic [7:0]  tr_data_in;
    logic        tr_grant;
    logic        tr_refused;
    logic [7:0]  tr_data_out;
    logic        reset_pin_is_reset;
    logic        scanner_enable;
    logic        prog_readout_protected;
    logic        data_readout_protected;
    int          errors;
    int          compares;

    nvmp_top #(.FAMILY_ID(TB_FAMILY), .MAJOR_REV(TB_MAJOR), .MINOR_REV(TB_MINOR),
               .PART_CODE(TB_PART)) dut (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cfg_wp_init(cfg_wp_init), .cfg_ro_init(cfg_ro_init), .cfg_tr_init(cfg_tr_init),
        .lvp_session(lvp_session), .ext_reset_pin_enable(ext_reset_pin_enable),
        .scanner_module_off(scanner_module_off), .wr_req(wr_req), .wr_space(wr_space),
        .wr_addr(wr_addr), .wr_commit(wr_commit), .wr_refused(wr_refused),
        .tr_req(tr_req), .tr_addr(tr_addr), .tr_src_addr(tr_src_addr),
        .tr_data_in(tr_data_in), .tr_grant(tr_grant), .tr_refused(tr_refused),
        .tr_data_out(tr_data_out), .reset_pin_is_reset(reset_pin_is_reset),
        .scanner_enable(scanner_enable), .prog_readout_protected(prog_readout_protected),
        .data_readout_protected(data_readout_protected));

    always #4 clock = ~clock;

    task automatic summarize;
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // level outputs follow their inputs one cycle late; three edges is ample
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic apply_reset(input logic [15:0] wp, input logic [15:0] ro,
                               input logic [15:0] tr);
        @(posedge clock);
        rstn        <= 1'b0;
        cfg_wp_init <= wp;
        cfg_ro_init <= ro;
        cfg_tr_init <= tr;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        // active image valid from the first edge after release, its pin and module outputs from the second
        settle();
    endtask

    task automatic reg_write(input logic [21:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input string name, input logic [21:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask

    task automatic wr_try(input logic [1:0] sp, input logic [16:0] a, input logic ok);
        @(posedge clock);
        wr_req   <= 1'b1;
        wr_space <= nvmp_space_t'(sp);
        wr_addr  <= a;
        @(posedge clock);
        wr_req <= 1'b0;
        #1;
        check("wr_commit", 16'(wr_commit), 16'(ok));
        check("wr_refused", 16'(wr_refused), 16'(!ok));
    endtask

    task automatic tr_try(input logic [16:0] a, input logic [16:0] src, input logic ok);
        @(posedge clock);
        tr_req      <= 1'b1;
        tr_addr     <= a;
        tr_src_addr <= src;
        tr_data_in  <= 8'h5a;
        @(posedge clock);
        tr_req <= 1'b0;
        #1;
        check("tr_grant", 16'(tr_grant), 16'(ok));
        check("tr_refused", 16'(tr_refused), 16'(!ok));
        check("tr_data_out", 16'(tr_data_out), ok ? 16'h005a : 16'h0000);
    endtask

    task automatic scn_erased;
        apply_reset(16'hffff, 16'hffff, 16'hffff);
        reg_read("wp_word", `NVMP_OFS_WP, 16'h37ff);
        reg_read("ro_word", `NVMP_OFS_RO, 16'h0003);
        reg_read("tr_word", `NVMP_OFS_TR, 16'h02ff);
        reg_read("revision", `NVMP_OFS_REV, {TB_FAMILY, TB_MAJOR, TB_MINOR});
        reg_read("part", `NVMP_OFS_PART, TB_PART);
        reg_read("unmapped", 22'h300010, 16'h0000);
        check("pin_reset", 16'(reset_pin_is_reset), 16'h0001);
        check("prog_prot", 16'(prog_readout_protected), 16'h0000);
        check("data_prot", 16'(data_readout_protected), 16'h0000);
        check("scan_on", 16'(scanner_enable), 16'h0001);
        @(posedge clock);
        scanner_module_off <= 1'b1;
        settle();
        check("scan_off", 16'(scanner_enable), 16'h0000);
        @(posedge clock);
        scanner_module_off <= 1'b0;
        wr_try(2'b01, 17'h0, 1'b1);
        wr_try(2'b10, 17'h0, 1'b1);
        wr_try(2'b00, 17'h00100, 1'b1);
        wr_try(2'b00, {3'd7, 14'h1000}, 1'b1);
        tr_try({3'd3, 14'h2000}, 17'h00100, 1'b1);
    endtask

    task automatic scn_locked;
        apply_reset(16'h0000, 16'h0000, 16'h0000);
        check("pin_gpio", 16'(reset_pin_is_reset), 16'h0000);
        @(posedge clock);
        ext_reset_pin_enable <= 1'b1;
        settle();
        check("pin_by_enable", 16'(reset_pin_is_reset), 16'h0001);
        @(posedge clock);
        ext_reset_pin_enable <= 1'b0;
        check("scan_locked", 16'(scanner_enable), 16'h0000);
        check("prog_prot", 16'(prog_readout_protected), 16'h0001);
        check("data_prot", 16'(data_readout_protected), 16'h0001);
        wr_try(2'b01, 17'h0, 1'b0);
        wr_try(2'b10, 17'h0, 1'b0);
        wr_try(2'b00, 17'h007ff, 1'b0);
        wr_try(2'b11, 17'h0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            wr_try(2'b00, {3'(k), 14'h1000}, 1'b0);
            tr_try({3'(k), 14'h2000}, 17'h00100, 1'b0);
        end
        tr_try(17'h00200, {3'd2, 14'h0}, 1'b0);
        tr_try({3'd4, 14'h0010}, {3'd4, 14'h3000}, 1'b1);
        reg_write(`NVMP_OFS_WP, 16'h37ff);
        reg_read("wp_locked", `NVMP_OFS_WP, 16'h0000);
        reg_write(`NVMP_OFS_RO, 16'hffff);
        reg_read("ro_readonly", `NVMP_OFS_RO, 16'h0000);
    endtask

    task automatic scn_mixed;
        apply_reset(16'h3155, 16'h0002, 16'h00aa);
        check("prog_prot", 16'(prog_readout_protected), 16'h0001);
        check("data_prot", 16'(data_readout_protected), 16'h0000);
        for (int k = 0; k < 8; k++) begin
            wr_try(2'b00, {3'(k), 14'h1000}, ~k[0]);
            tr_try({3'(k), 14'h2000}, 17'h00100, k[0]);
        end
        wr_try(2'b00, 17'h00000, 1'b0);
        wr_try(2'b01, 17'h0, 1'b0);
        wr_try(2'b10, 17'h0, 1'b1);
        tr_try(17'h00400, {3'd1, 14'h0}, 1'b0);
        reg_write(`NVMP_OFS_TR, 16'h0201);
        reg_read("tr_open", `NVMP_OFS_TR, 16'h0201);
        // the session pin crosses a two-flop synchroniser first
        // a low-voltage session is only opened while low-voltage enable is set
        @(posedge clock);
        lvp_session <= 1'b1;
        settle();
        reg_write(`NVMP_OFS_WP, 16'h0000);
        reg_read("lvp_kept", `NVMP_OFS_WP, 16'h2000);
        @(posedge clock);
        lvp_session <= 1'b0;
        settle();
        reg_write(`NVMP_OFS_WP, 16'h0000);
        reg_read("lvp_cleared", `NVMP_OFS_WP, 16'h0000);
        wr_try(2'b00, {3'd2, 14'h1000}, 1'b1);
        tr_try(17'h00400, {3'd1, 14'h0}, 1'b0);
    endtask

    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cfg_wp_init = 16'hffff;
        cfg_ro_init = 16'hffff;
        cfg_tr_init = 16'hffff;
        lvp_session = 1'b0;
        ext_reset_pin_enable = 1'b0;
        scanner_module_off = 1'b0;
        wr_req = 1'b0;
        wr_space = SP_PROG;
        wr_addr = '0;
        tr_req = 1'b0;
        tr_addr = '0;
        tr_src_addr = '0;
        tr_data_in = '0;
        errors = 0;
        compares = 0;
        scn_erased();
        scn_locked();
        scn_mixed();
        summarize();
    end

    // hang guard well above the fewer than two hundred cycles the scenarios need
    initial begin
        #400000;
        errors++;
        summarize();
    end
endmodule
